/* File: inc/pmic_regs_defines.svh */
// Offsets, field positions, reset values and timing counts of the bank.
`ifndef PMIC_REGS_DEFINES_SVH
`define PMIC_REGS_DEFINES_SVH

// Register addresses, nine bits wide; the in-bank bank control address is seven.
`define OFF_BANK_CTL 9'h000
`define OFF_STATUS_A 9'h001
`define OFF_STATUS_B 9'h002
`define OFF_STATUS_D 9'h004
`define OFF_FAULT 9'h005
`define OFF_EVENT_A 9'h006
`define OFF_EVENT_B 9'h007
`define OFF_EVENT_C 9'h008
`define OFF_MASK_A 9'h00a
`define BANK_LOW_ADDR 7'h00

// Bank control fields.
`define BANK_RETURN_BIT 7
`define BANK_STYLE_BIT 6
`define BANK_SEL_MSB 1
`define BANK_SEL_LSB 0
`define BANK_SEL_ZERO 2'h0

// Valid-bit masks and reset values.
`define EVA_VALID 8'h1f
`define EVB_VALID 8'haa
`define EVC_VALID 8'h1f
`define REG_RESET 8'h00
`define BYTE_ZERO 8'h00

// Serial byte framing.
`define BYTE_BITS 4'h8
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1

// Early undervoltage window.
`define EARLY_UV_TIME_S 16
`define CLK_HZ 10000000
`define EARLY_UV_CYCLES (`EARLY_UV_TIME_S * `CLK_HZ)
`define TIMER_ZERO 28'h000_0000
`define TIMER_ONE 28'h000_0001

`endif

/* File: inc/pmic_regs_pkg.sv */
// Types shared by the register bank.
package pmic_regs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEV, ST_RX, ST_ACK, ST_TX, ST_MACK
  } serial_state_e;
  typedef logic [8:0] reg_addr_t;
endpackage

/* File: rtl/pmic_page_status_event_regs.sv */
// Banked status, shutdown log, event and mask registers on a 2-wire slave.
`timescale 1ns/1ns
`default_nettype none
`include "pmic_regs_defines.svh"

module pmic_page_status_event_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary value.
  parameter int EARLY_UV_CYCLES = `EARLY_UV_CYCLES,
  parameter int SUPPLIES = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // 2-wire host pins, open drain.
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Pin levels from outside the clock domain.
  input wire logic powerKeyLevel,
  input wire logic [4:0] gpiLevel,
  // Levels from on-chip logic.
  input wire logic [SUPPLIES-1:0] rampActive,
  input wire logic [3:0] ldoOvercurrent,
  input wire logic systemResetReleased,
  input wire logic [7:0] maskB,
  input wire logic [7:0] maskC,
  // Shutdown causes, one-cycle pulses.
  input wire logic stepTimeoutShutdown,
  input wire logic resetRequestPinShutdown,
  input wire logic softwareShutdown,
  input wire logic powerKeyShutdown,
  input wire logic tempCritShutdown,
  input wire logic undervoltageShutdown,
  input wire logic coldStart,
  input wire logic watchdogShutdown,
  // Events, one-cycle pulses.
  input wire logic sequenceDone,
  input wire logic watchdogWarn,
  input wire logic rtcTick,
  input wire logic rtcAlarm,
  input wire logic powerKeyEvent,
  input wire logic supplyLow,
  input wire logic ldoLimit,
  input wire logic tempWarn,
  input wire logic [4:0] gpiEvent,
  // Interrupt request, active high.
  output logic irqActive
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pmic_regs_pkg::serial_state_e state_ff;
  logic sclS1_ff, sclS2_ff, sclD_ff, sdaS1_ff, sdaS2_ff, sdaD_ff;
  logic keyS1_ff, keyS2_ff;
  logic [4:0] gpiS1_ff, gpiS2_ff;
  logic sclRise, sclFall, startCond, stopCond;
  logic [3:0] cnt_ff;
  logic [7:0] sh_ff, txSh_ff;
  logic [6:0] ptr_ff;
  logic readMode_ff, addrPhase_ff, masterAck_ff, sdaOe_ff;
  logic wrStb_ff, rdStb_ff;
  pmic_regs_pkg::reg_addr_t wrAddr_ff;
  logic [7:0] wrData_ff;
  logic [7:0] bankCtl_ff, fault_ff, evA_ff, evB_ff, evC_ff, maskA_ff;
  logic [7:0] rdByte, faultSet, evBSet;
  logic [1:0] bankSel;
  pmic_regs_pkg::reg_addr_t curAddr;
  logic rampBusy, rampBusyD_ff, rampDone;
  logic [27:0] uvTimer_ff;
  logic earlyWindow;
  logic irq_ff;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // The bank control copy sits at the bottom of every bank.
  function automatic logic isBankCtl(input pmic_regs_pkg::reg_addr_t a);
    isBankCtl = (a[6:0] == `BANK_LOW_ADDR);
  endfunction

  function automatic logic hit(input pmic_regs_pkg::reg_addr_t a,
                               input pmic_regs_pkg::reg_addr_t off);
    hit = (a == off);
  endfunction

  // Write-to-clear strobe for a given register.
  function automatic logic [7:0] clrMask(input logic stb,
                                         input pmic_regs_pkg::reg_addr_t a,
                                         input pmic_regs_pkg::reg_addr_t off,
                                         input logic [7:0] d);
    clrMask = (stb && (a == off)) ? d : `BYTE_ZERO;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages per pin; the delayed copy reads only the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclS1_ff <= 1'b1;
      sclS2_ff <= 1'b1;
      sclD_ff <= 1'b1;
      sdaS1_ff <= 1'b1;
      sdaS2_ff <= 1'b1;
      sdaD_ff <= 1'b1;
      keyS1_ff <= 1'b0;
      keyS2_ff <= 1'b0;
      gpiS1_ff <= 5'h00;
      gpiS2_ff <= 5'h00;
    end else begin
      sclS1_ff <= sclIn;
      sclS2_ff <= sclS1_ff;
      sclD_ff <= sclS2_ff;
      sdaS1_ff <= sdaIn;
      sdaS2_ff <= sdaS1_ff;
      sdaD_ff <= sdaS2_ff;
      keyS1_ff <= powerKeyLevel;
      keyS2_ff <= keyS1_ff;
      gpiS1_ff <= gpiLevel;
      gpiS2_ff <= gpiS1_ff;
    end
  end

  // Bus conditions seen after synchronisation.
  assign sclRise = sclS2_ff & ~sclD_ff;
  assign sclFall = ~sclS2_ff & sclD_ff;
  assign startCond = sclS2_ff & sclD_ff & sdaD_ff & ~sdaS2_ff;
  assign stopCond = sclS2_ff & sclD_ff & ~sdaD_ff & sdaS2_ff;
  assign bankSel = bankCtl_ff[`BANK_SEL_MSB:`BANK_SEL_LSB];
  assign curAddr = {bankSel, ptr_ff};
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_ff;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  // Unmapped addresses and reserved status and event bits read as zero; bank control and mask A read back all eight written bits.
  always_comb begin
    rdByte = `BYTE_ZERO;
    if (isBankCtl(curAddr)) begin
      rdByte = bankCtl_ff;
    end else if (hit(curAddr, `OFF_STATUS_A)) begin
      rdByte = {5'h00, rampBusy, 1'b0, keyS2_ff};
    end else if (hit(curAddr, `OFF_STATUS_B)) begin
      rdByte = {3'h0, gpiS2_ff};
    end else if (hit(curAddr, `OFF_STATUS_D)) begin
      rdByte = {4'h0, ldoOvercurrent};
    end else if (hit(curAddr, `OFF_FAULT)) begin
      rdByte = fault_ff;
    end else if (hit(curAddr, `OFF_EVENT_A)) begin
      // Summary bits are live ORs, not stored flags.
      rdByte = {1'b0, |evC_ff, |evB_ff, evA_ff[4:0]};
    end else if (hit(curAddr, `OFF_EVENT_B)) begin
      rdByte = evB_ff;
    end else if (hit(curAddr, `OFF_EVENT_C)) begin
      rdByte = evC_ff;
    end else if (hit(curAddr, `OFF_MASK_A)) begin
      rdByte = maskA_ff;
    end
  end

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  // Bytes are taken on SCL edges; the acknowledge is held across one
  // full clock so the host sees it however slowly it runs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= pmic_regs_pkg::ST_IDLE;
      cnt_ff <= `CNT_ZERO;
      sh_ff <= `BYTE_ZERO;
      txSh_ff <= `BYTE_ZERO;
      ptr_ff <= 7'h00;
      readMode_ff <= 1'b0;
      addrPhase_ff <= 1'b0;
      masterAck_ff <= 1'b0;
      sdaOe_ff <= 1'b0;
      wrStb_ff <= 1'b0;
      rdStb_ff <= 1'b0;
      wrAddr_ff <= `OFF_BANK_CTL;
      wrData_ff <= `BYTE_ZERO;
    end else begin
      wrStb_ff <= 1'b0;
      rdStb_ff <= 1'b0;
      if (startCond) begin
        state_ff <= pmic_regs_pkg::ST_DEV;
        cnt_ff <= `CNT_ZERO;
        sdaOe_ff <= 1'b0;
      end else if (stopCond) begin
        state_ff <= pmic_regs_pkg::ST_IDLE;
        sdaOe_ff <= 1'b0;
      end else begin
        unique case (state_ff)
          pmic_regs_pkg::ST_IDLE: begin
            sdaOe_ff <= 1'b0;
          end
          pmic_regs_pkg::ST_DEV, pmic_regs_pkg::ST_RX: begin
            if (sclRise) begin
              sh_ff <= {sh_ff[6:0], sdaS2_ff};
              cnt_ff <= cnt_ff + `CNT_ONE;
            end else if (sclFall && cnt_ff == `BYTE_BITS) begin
              cnt_ff <= `CNT_ZERO;
              if (state_ff == pmic_regs_pkg::ST_DEV) begin
                if (sh_ff[7:1] == DEV_ADDR) begin
                  sdaOe_ff <= 1'b1;
                  state_ff <= pmic_regs_pkg::ST_ACK;
                  readMode_ff <= sh_ff[0];
                  addrPhase_ff <= 1'b1;
                end else begin
                  state_ff <= pmic_regs_pkg::ST_IDLE;
                end
              end else begin
                sdaOe_ff <= 1'b1;
                state_ff <= pmic_regs_pkg::ST_ACK;
                if (addrPhase_ff) begin
                  ptr_ff <= sh_ff[6:0];
                  addrPhase_ff <= 1'b0;
                end else begin
                  wrStb_ff <= 1'b1;
                  wrAddr_ff <= curAddr;
                  wrData_ff <= sh_ff;
                  if (bankCtl_ff[`BANK_STYLE_BIT]) begin
                    addrPhase_ff <= 1'b1;
                  end else begin
                    ptr_ff <= ptr_ff + 7'h01;
                  end
                end
              end
            end
          end
          pmic_regs_pkg::ST_ACK: begin
            if (sclFall) begin
              if (readMode_ff) begin
                txSh_ff <= rdByte;
                sdaOe_ff <= ~rdByte[7];
                rdStb_ff <= 1'b1;
                ptr_ff <= ptr_ff + 7'h01;
                state_ff <= pmic_regs_pkg::ST_TX;
              end else begin
                sdaOe_ff <= 1'b0;
                state_ff <= pmic_regs_pkg::ST_RX;
              end
            end
          end
          pmic_regs_pkg::ST_TX: begin
            if (sclRise) begin
              cnt_ff <= cnt_ff + `CNT_ONE;
            end else if (sclFall) begin
              if (cnt_ff == `BYTE_BITS) begin
                cnt_ff <= `CNT_ZERO;
                sdaOe_ff <= 1'b0;
                state_ff <= pmic_regs_pkg::ST_MACK;
              end else begin
                txSh_ff <= {txSh_ff[6:0], 1'b0};
                sdaOe_ff <= ~txSh_ff[6];
              end
            end
          end
          pmic_regs_pkg::ST_MACK: begin
            if (sclRise) begin
              masterAck_ff <= ~sdaS2_ff;
            end else if (sclFall) begin
              if (masterAck_ff) begin
                txSh_ff <= rdByte;
                sdaOe_ff <= ~rdByte[7];
                rdStb_ff <= 1'b1;
                ptr_ff <= ptr_ff + 7'h01;
                state_ff <= pmic_regs_pkg::ST_TX;
              end else begin
                state_ff <= pmic_regs_pkg::ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Bank control
  // ----------------------------------------------------------------
  // A write to any copy updates the one register; auto-return only acts
  // on accesses that did not themselves rewrite the bank.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bankCtl_ff <= `REG_RESET;
    end else if (wrStb_ff && isBankCtl(wrAddr_ff)) begin
      bankCtl_ff <= wrData_ff;
    end else if ((wrStb_ff || rdStb_ff) && bankCtl_ff[`BANK_RETURN_BIT]) begin
      bankCtl_ff[`BANK_SEL_MSB:`BANK_SEL_LSB] <= `BANK_SEL_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Early undervoltage window
  // ----------------------------------------------------------------
  // Counts from reset release and saturates; held reset restarts it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      uvTimer_ff <= `TIMER_ZERO;
    end else if (!systemResetReleased) begin
      uvTimer_ff <= `TIMER_ZERO;
    end else if (uvTimer_ff < 28'(EARLY_UV_CYCLES)) begin
      uvTimer_ff <= uvTimer_ff + `TIMER_ONE;
    end
  end

  assign earlyWindow = !systemResetReleased ||
                       (uvTimer_ff < 28'(EARLY_UV_CYCLES));

  // ----------------------------------------------------------------
  // Shutdown cause log
  // ----------------------------------------------------------------
  // New causes win over a host clear in the same cycle.
  always_comb begin
    faultSet = {stepTimeoutShutdown,
                resetRequestPinShutdown | softwareShutdown,
                powerKeyShutdown,
                tempCritShutdown,
                undervoltageShutdown & earlyWindow,
                undervoltageShutdown,
                coldStart,
                watchdogShutdown};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fault_ff <= `REG_RESET;
    end else begin
      fault_ff <= (fault_ff & ~clrMask(wrStb_ff, wrAddr_ff, `OFF_FAULT,
                   wrData_ff)) | faultSet;
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Ramp-done fires on the fall of the combined busy level.
  assign rampBusy = |rampActive;
  assign rampDone = rampBusyD_ff & ~rampBusy;
  assign evBSet = {supplyLow, 1'b0, rampDone, 1'b0,
                   ldoLimit, 1'b0, tempWarn, 1'b0};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rampBusyD_ff <= 1'b0;
    end else begin
      rampBusyD_ff <= rampBusy;
    end
  end

  // Reserved positions are masked out of both set and stored value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evA_ff <= `REG_RESET;
      evB_ff <= `REG_RESET;
      evC_ff <= `REG_RESET;
    end else begin
      evA_ff <= ((evA_ff & ~clrMask(wrStb_ff, wrAddr_ff, `OFF_EVENT_A,
                 wrData_ff)) | {3'h0, sequenceDone, watchdogWarn, rtcTick,
                 rtcAlarm, powerKeyEvent}) & `EVA_VALID;
      evB_ff <= ((evB_ff & ~clrMask(wrStb_ff, wrAddr_ff, `OFF_EVENT_B,
                 wrData_ff)) | evBSet) & `EVB_VALID;
      evC_ff <= ((evC_ff & ~clrMask(wrStb_ff, wrAddr_ff, `OFF_EVENT_C,
                 wrData_ff)) | {3'h0, gpiEvent}) & `EVC_VALID;
    end
  end

  // ----------------------------------------------------------------
  // Masks and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      maskA_ff <= `REG_RESET;
    end else if (wrStb_ff && hit(wrAddr_ff, `OFF_MASK_A)) begin
      maskA_ff <= wrData_ff;
    end
  end

  // Registered so the pin never glitches on decode transients.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evA_ff & ~maskA_ff & `EVA_VALID) |
                |(evB_ff & ~maskB) | |(evC_ff & ~maskC);
    end
  end

  assign irqActive = irq_ff;

endmodule
`default_nettype wire

/* File: test/pmic_regs_chk.sv */
// Pin-level assertions for the banked status and event registers.
`timescale 1ns/1ns
`default_nettype none
module pmic_regs_chk #(
  parameter int SUPPLIES = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Serial pins.
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  // Event sources and masks.
  input wire logic [SUPPLIES-1:0] rampActive,
  input wire logic [7:0] maskB,
  input wire logic [7:0] maskC,
  input wire logic supplyLow,
  input wire logic ldoLimit,
  input wire logic tempWarn,
  input wire logic [4:0] gpiEvent,
  // Interrupt.
  input wire logic irqActive
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Open drain: the driven value is always low, only the enable moves.
  sda_low_only_a: assert property (sdaOut == 1'b0)
    else $error("sda driven value not low");
  // A move while SCL is high would look like a start or stop condition.
  sda_moves_low_a: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("sda enable changed while scl high");
  irq_after_reset_a: assert property ($fell(rst) |-> !irqActive)
    else $error("irq active after reset");
  // Unmasked events must reach the request line within a few cycles.
  supply_low_irq_a: assert property (
    supplyLow && !maskB[7] |-> ##[1:3] irqActive)
    else $error("supply low event gave no irq");
  ldo_limit_irq_a: assert property (
    ldoLimit && !maskB[3] |-> ##[1:3] irqActive)
    else $error("ldo limit event gave no irq");
  temp_warn_irq_a: assert property (
    tempWarn && !maskB[1] |-> ##[1:3] irqActive)
    else $error("temperature event gave no irq");
  gpi_event_irq_a: assert property (
    |(gpiEvent & ~maskC[4:0]) |-> ##[1:3] irqActive)
    else $error("input event gave no irq");
  ramp_done_irq_a: assert property (
    $fell(|rampActive) && !maskB[5] |-> ##[1:4] irqActive)
    else $error("ramp end gave no irq");
endmodule
bind pmic_page_status_event_regs pmic_regs_chk #(.SUPPLIES(SUPPLIES)) chk (
  .clk, .rst, .sclIn, .sdaOut, .sdaOe, .rampActive, .maskB, .maskC,
  .supplyLow, .ldoLimit, .tempWarn, .gpiEvent, .irqActive);
`default_nettype wire

/* File: test/host_model.sv */
// Behavioural 2-wire host that pulls SDA low and drives SCL.
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock.
  input wire logic clk,
  // Bus lines.
  input wire logic sda,
  output logic scl,
  output logic sdaLow
);
  // Idle bus: SCL high, SDA released to its pull-up.
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One SCL period; SDA only moves three cycles after SCL fell.
  task automatic bitc(input logic low, output logic s);
    sdaLow <= low;
    w(4);
    scl <= 1'b1;
    w(4);
    s = sda;
    w(1);
    scl <= 1'b0;
    w(3);
  endtask
  // Start and repeated start share one shape.
  task automatic start();
    sdaLow <= 1'b0;
    w(4);
    scl <= 1'b1;
    w(5);
    sdaLow <= 1'b1;
    w(5);
    scl <= 1'b0;
    w(3);
  endtask
  task automatic stop();
    sdaLow <= 1'b1;
    w(4);
    scl <= 1'b1;
    w(5);
    sdaLow <= 1'b0;
    w(5);
  endtask
  // Byte out, MSB first; ack is the level seen in the ninth period.
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitc(~b[i], s);
    end
    bitc(1'b0, ack);
  endtask
  // Byte in; a NACK ends a read.
  task automatic recv(input logic nack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitc(1'b0, b[i]);
    end
    bitc(~nack, s);
  endtask
endmodule
`default_nettype wire

/* File: test/test_pmic_page_status_event_regs.sv */
// Self-checking bench for the banked status and event registers.
`timescale 1ns/1ns
`default_nettype none
module test_pmic_page_status_event_regs;
  logic clk, rst, scl, sdaLow, sdaOut, sdaOe, irqActive, powerKeyLevel;
  logic systemResetReleased, sequenceDone, watchdogWarn, rtcTick, rtcAlarm;
  logic powerKeyEvent, supplyLow, ldoLimit, tempWarn;
  logic stepTimeoutShutdown, resetRequestPinShutdown, softwareShutdown;
  logic powerKeyShutdown, tempCritShutdown, undervoltageShutdown;
  logic coldStart, watchdogShutdown;
  logic [4:0] gpiLevel, gpiEvent;
  logic [3:0] rampActive, ldoOvercurrent;
  logic [7:0] maskB, maskC;
  wire sda;
  int failCount = 0;
  int checked = 0;
  // Expected log values, one byte per shutdown cause in port order.
  localparam logic [63:0] FEXP = 64'h8040_4020_100c_0201;
  // Wired-AND bus with a pull-up.
  assign sda = ~(sdaLow | sdaOe);
  always #50 clk = ~clk;
  host_model host (.clk, .sda, .scl, .sdaLow);
  pmic_page_status_event_regs #(.EARLY_UV_CYCLES(50)) DUT (
    .clk, .rst, .sclIn(scl), .sdaIn(sda), .sdaOut, .sdaOe, .powerKeyLevel,
    .gpiLevel, .rampActive, .ldoOvercurrent, .systemResetReleased, .maskB,
    .maskC, .stepTimeoutShutdown, .resetRequestPinShutdown,
    .softwareShutdown, .powerKeyShutdown, .tempCritShutdown,
    .undervoltageShutdown, .coldStart, .watchdogShutdown, .sequenceDone,
    .watchdogWarn, .rtcTick, .rtcAlarm, .powerKeyEvent, .supplyLow,
    .ldoLimit, .tempWarn, .gpiEvent, .irqActive);
  task automatic chk(input string n, input logic [7:0] s, e);
    checked++;
    if (s !== e) begin
      failCount++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (failCount == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Device address first, then the bytes as given; each must be acked.
  task automatic wrSeq(input logic [7:0] q[$]);
    logic a;
    q.push_front(8'h54);
    host.start();
    foreach (q[i]) begin
      host.send(q[i], a);
      chk("ack", {7'h0, a}, 8'h00);
    end
    host.stop();
  endtask
  task automatic rd(input logic [6:0] p, input logic [7:0] e, input string n);
    logic a;
    logic [7:0] d;
    wrSeq({{1'b0, p}});
    host.start();
    host.send(8'h55, a);
    host.recv(1'b1, d);
    host.stop();
    chk(n, d, e);
  endtask
  // Raise event and cause pulses for exactly one cycle.
  task automatic pulse(input logic [4:0] a, input logic [2:0] b,
                       input logic [4:0] g, input logic [7:0] c);
    {sequenceDone, watchdogWarn, rtcTick, rtcAlarm, powerKeyEvent} <= a;
    {supplyLow, ldoLimit, tempWarn} <= b;
    gpiEvent <= g;
    {stepTimeoutShutdown, resetRequestPinShutdown, softwareShutdown,
     powerKeyShutdown, tempCritShutdown, undervoltageShutdown, coldStart,
     watchdogShutdown} <= c;
    host.w(1);
    pulse0();
  endtask
  task automatic pulse0();
    {sequenceDone, watchdogWarn, rtcTick, rtcAlarm, powerKeyEvent} <= 5'h00;
    {supplyLow, ldoLimit, tempWarn} <= 3'h0;
    gpiEvent <= 5'h00;
    {stepTimeoutShutdown, resetRequestPinShutdown, softwareShutdown,
     powerKeyShutdown, tempCritShutdown, undervoltageShutdown, coldStart,
     watchdogShutdown} <= 8'h00;
  endtask
  // Bank selection, its mirror, persistence and a refused address.
  task automatic bankSelect();
    logic a;
    rd(7'h0a, 8'h00, "mask reset");
    host.start();
    host.send(8'h56, a);
    host.stop();
    chk("nack", {7'h0, a}, 8'h01);
    wrSeq({8'h0a, 8'h15});
    wrSeq({8'h00, 8'h3d});
    rd(7'h00, 8'h3d, "bank mirror");
    rd(7'h0a, 8'h00, "bank one");
    wrSeq({8'h00, 8'h00});
    rd(7'h0a, 8'h15, "bank zero");
  endtask
  task automatic autoReturn();
    wrSeq({8'h00, 8'h82});
    rd(7'h0a, 8'h00, "bank two");
    rd(7'h00, 8'h80, "returned");
    rd(7'h0a, 8'h15, "after return");
    wrSeq({8'h00, 8'h00});
  endtask
  // Style 0 fills consecutive places, style 1 takes address/data pairs.
  task automatic burstStyle();
    wrSeq({8'h09, 8'haa, 8'h13});
    rd(7'h0a, 8'h13, "burst seq");
    wrSeq({8'h00, 8'h40});
    wrSeq({8'h09, 8'hee, 8'h0a, 8'h07});
    rd(7'h0a, 8'h07, "burst pairs");
    wrSeq({8'h00, 8'h00});
  endtask
  task automatic statusRead();
    logic b;
    rampActive <= 4'h2;
    wrSeq({8'h01, 8'hff});
    // Two complementary level patterns, so every key, input and overcurrent status bit reads both ways.
    for (int k = 0; k < 2; k++) begin
      b = k[0];
      powerKeyLevel <= b;
      gpiLevel <= 5'h0a ^ {5{b}};
      ldoOvercurrent <= 4'h6 ^ {4{b}};
      rd(7'h01, {5'h00, 1'b1, 1'b0, b}, "status a");
      rd(7'h02, {3'h0, 5'h0a ^ {5{b}}}, "status b");
      rd(7'h04, {4'h0, 4'h6 ^ {4{b}}}, "status d");
    end
    rampActive <= 4'h0;
    rd(7'h07, 8'h20, "ramp done");
    wrSeq({8'h07, 8'h20});
    rd(7'h01, 8'h01, "ramp idle");
  endtask
  // Each system event latched, masked, kept on a wrong write, cleared.
  task automatic systemEvents();
    logic [7:0] m;
    wrSeq({8'h0a, 8'h00});
    for (int i = 0; i < 5; i++) begin
      m = 8'h01 << i;
      pulse(m[4:0], 3'h0, 5'h00, 8'h00);
      rd(7'h06, m, "event a");
      wrSeq({8'h0a, m});
      chk("irq masked", {7'h0, irqActive}, 8'h00);
      wrSeq({8'h0a, 8'h00});
      chk("irq open", {7'h0, irqActive}, 8'h01);
      wrSeq({8'h06, ~m & 8'h1f});
      rd(7'h06, m, "event kept");
      wrSeq({8'h06, m});
      chk("irq clear", {7'h0, irqActive}, 8'h00);
    end
  endtask
  task automatic supplyEvents();
    pulse(5'h00, 3'h7, 5'h1f, 8'h00);
    rd(7'h06, 8'h60, "summary");
    rd(7'h07, 8'h8a, "event b");
    rd(7'h08, 8'h1f, "event c");
    wrSeq({8'h0a, 8'hff});
    maskB <= 8'hff;
    maskC <= 8'hff;
    host.w(4);
    chk("irq masked bc", {7'h0, irqActive}, 8'h00);
    wrSeq({8'h0a, 8'h00});
    maskB <= 8'h00;
    maskC <= 8'h00;
    wrSeq({8'h07, 8'h8a});
    wrSeq({8'h08, 8'h1f});
    rd(7'h06, 8'h00, "summary clear");
    chk("irq idle", {7'h0, irqActive}, 8'h00);
  endtask
  // Every shutdown cause, then undervoltage inside and outside the window.
  task automatic faultLog();
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      e = FEXP[63-8*i -: 8];
      pulse(5'h00, 3'h0, 5'h00, 8'h80 >> i);
      rd(7'h05, e, "fault log");
      wrSeq({8'h05, e});
      rd(7'h05, 8'h00, "fault clear");
    end
    systemResetReleased <= 1'b1;
    pulse(5'h00, 3'h0, 5'h00, 8'h04);
    rd(7'h05, 8'h0c, "uv early");
    wrSeq({8'h05, 8'h0c});
    pulse(5'h00, 3'h0, 5'h00, 8'h04);
    rd(7'h05, 8'h04, "uv late");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    powerKeyLevel = 1'b0;
    gpiLevel = 5'h00;
    rampActive = 4'h0;
    ldoOvercurrent = 4'h0;
    systemResetReleased = 1'b0;
    maskB = 8'h00;
    maskC = 8'h00;
    pulse0();
    host.w(10);
    rst <= 1'b0;
    host.w(3);
    bankSelect();
    autoReturn();
    burstStyle();
    statusRead();
    systemEvents();
    supplyEvents();
    faultLog();
    tally_and_finish();
  end
  // Guard against a hung bus; the run needs about 40700 cycles.
  initial begin
    host.w(95000);
    failCount++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
